// [core/lfa_pkg.sv]
// Constants, register map and carrier types for the LED fault alert block.
package lfa_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int QUAL_TIME_NS = 15000;
  localparam int QUAL_CYCLES = (QUAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] QUAL_LAST = 12'(QUAL_CYCLES - 1);

  // ---------------------------------------------------------------
  // Bus addresses and channel count
  // ---------------------------------------------------------------
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [2:0] ALERT_ADDR_HI = 3'h2;
  localparam int NUM_CH = 8;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OPEN_STATUS = 8'h00;
  localparam logic [7:0] OFS_SHORT_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [0:0] CTRL_RST = 1'h1;
  localparam int IRQ_OPEN = 0;
  localparam int IRQ_SHORT = 1;
  localparam int IRQ_HEAT = 2;
  localparam int IRQ_ARA_DONE = 3;
  localparam int IRQ_ARB_LOST = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ARA_IDLE = 3'b000,
    ARA_ADDR_RX = 3'b001,
    ARA_ACK = 3'b010,
    ARA_SEND = 3'b011,
    ARA_MACK = 3'b100,
    ARA_WAIT = 3'b101
  } lfa_ara_state_type;

  typedef struct packed {
    logic [7:0] above_hard;
    logic [7:0] above_open;
    logic [7:0] below_short;
    logic over_170;
    logic below_160;
  } lfa_sense_type;

  typedef struct packed {
    logic stop;
    logic all_channel_command;
    logic single_channel_command;
    logic [2:0] channel;
    logic data_all_ones;
  } lfa_cmd_type;

endpackage

// [core/lfa_fault_alert.sv]
// Fault detection, fault status, alert output and alert response for eight LED channels.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module lfa_fault_alert
  import lfa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] address_select_pins,
  // Alert pin, open drain
  output logic alert_n_out,
  output logic alert_n_oe,
  // Analog sense and command decoder
  input wire lfa_sense_type sense,
  input wire lfa_cmd_type cmd,
  // Switch control and interrupt
  output logic [7:0] force_switch_on,
  output logic irq
);
  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Fault qualification
  // ---------------------------------------------------------------
  logic [11:0] open_cnt_ff [NUM_CH], short_cnt_ff [NUM_CH];
  logic [7:0] open_evt, short_evt;
  logic ctrl_enable_ff;

  function automatic logic [11:0] qual_next(input logic cond, input logic [11:0] cnt);
    if (!cond) begin
      return 12'h000;
    end
    return (cnt > QUAL_LAST) ? cnt : cnt + 12'h001; // Parks past the end, so a held fault fires once.
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        open_cnt_ff[i] <= 12'h000;
        short_cnt_ff[i] <= 12'h000;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        open_cnt_ff[i] <= qual_next(sense.above_open[i], open_cnt_ff[i]);
        short_cnt_ff[i] <= qual_next(sense.below_short[i], short_cnt_ff[i]);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      open_evt[i] = ctrl_enable_ff && (sense.above_hard[i] ||
                    (sense.above_open[i] && open_cnt_ff[i] == QUAL_LAST));
      short_evt[i] = ctrl_enable_ff && sense.below_short[i] &&
                     short_cnt_ff[i] == QUAL_LAST;
    end
  end

  // ---------------------------------------------------------------
  // Fault status, overheat and switch forcing
  // ---------------------------------------------------------------
  logic [7:0] open_fault_status_ff, short_fault_status_ff, force_ff;
  logic [7:0] hit_ch, clr_open, clr_short;
  logic heat_latched_ff, heat_clear, any_set_evt, ara_done, alert_ff;

  always_comb begin
    hit_ch = 8'h00;
    if (cmd.stop && cmd.all_channel_command) begin
      hit_ch = 8'hff;
    end else if (cmd.stop && cmd.single_channel_command) begin
      hit_ch = 8'h01 << cmd.channel;
    end
    heat_clear = heat_latched_ff && cmd.stop && cmd.all_channel_command &&
                 cmd.data_all_ones && sense.below_160;
    clr_open = (heat_latched_ff && !heat_clear) ? 8'h00 :
               hit_ch & ~sense.above_open & ~sense.above_hard;
    clr_short = (heat_latched_ff && !heat_clear) ? 8'h00 :
                hit_ch & ~sense.below_short;
    any_set_evt = |open_evt || |short_evt || sense.over_170;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_fault_status_ff <= 8'h00;
      short_fault_status_ff <= 8'h00;
      heat_latched_ff <= 1'b0;
    end else begin
      if (sense.over_170) begin
        open_fault_status_ff <= 8'hff;
        short_fault_status_ff <= 8'hff;
        heat_latched_ff <= 1'b1;
      end else begin
        open_fault_status_ff <= (open_fault_status_ff & ~clr_open) | open_evt;
        short_fault_status_ff <= (short_fault_status_ff & ~clr_short) | short_evt;
        if (heat_clear) begin
          heat_latched_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_ff <= 8'h00;
    end else if (sense.over_170) begin
      force_ff <= 8'hff;
    end else begin
      force_ff <= (force_ff & ~clr_open) | open_evt;
    end
  end

  assign force_switch_on = force_ff;

  // ---------------------------------------------------------------
  // Alert output
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_ff <= 1'b0;
    end else if (any_set_evt) begin
      alert_ff <= 1'b1;
    end else if (|hit_ch && (|(open_fault_status_ff & ~clr_open) ||
                             |(short_fault_status_ff & ~clr_short))) begin
      alert_ff <= 1'b1;
    end else if (ara_done || (open_fault_status_ff == 8'h00 &&
                              short_fault_status_ff == 8'h00)) begin
      alert_ff <= 1'b0;
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_ff;

  // ---------------------------------------------------------------
  // Alert response engine
  // ---------------------------------------------------------------
  lfa_ara_state_type ara_state_ff;
  logic scl_q_ff, sda_q_ff, sda_oe_ff;
  logic [7:0] shift_ff, reply;
  logic [3:0] bit_cnt_ff;
  logic arb_lost, scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = scl_in && !scl_q_ff;
  assign scl_fall = !scl_in && scl_q_ff;
  assign start_cond = scl_in && scl_q_ff && sda_q_ff && !sda_in;
  assign stop_cond = scl_in && scl_q_ff && !sda_q_ff && sda_in;
  assign reply = {ALERT_ADDR_HI, address_select_pins, 1'b1};
  assign arb_lost = ara_state_ff == ARA_SEND && scl_rise &&
                    reply[3'(7 - bit_cnt_ff)] && !sda_in;
  assign ara_done = ara_state_ff == ARA_SEND && scl_fall && bit_cnt_ff == 4'h8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ara_state_ff <= ARA_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (start_cond) begin
      ara_state_ff <= ARA_ADDR_RX;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (stop_cond) begin
      ara_state_ff <= ARA_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (ara_state_ff)
        ARA_ADDR_RX: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_in};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (scl_fall && bit_cnt_ff == 4'h8) begin
            if (shift_ff == {ARA_ADDR, 1'b1} && alert_ff) begin
              ara_state_ff <= ARA_ACK;
              sda_oe_ff <= 1'b1;
            end else begin
              ara_state_ff <= ARA_WAIT;
            end
          end
        end
        ARA_ACK: begin
          if (scl_fall) begin
            ara_state_ff <= ARA_SEND;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= !reply[7];
          end
        end
        ARA_SEND: begin
          if (arb_lost) begin
            ara_state_ff <= ARA_WAIT;
            sda_oe_ff <= 1'b0;
          end else if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              ara_state_ff <= ARA_MACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sda_oe_ff <= !reply[3'(7 - bit_cnt_ff)];
            end
          end
        end
        ARA_MACK: begin
          if (scl_fall) begin
            ara_state_ff <= ARA_WAIT;
          end
        end
        ARA_IDLE, ARA_WAIT: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          ara_state_ff <= ARA_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;

  // ---------------------------------------------------------------
  // Register bus and interrupt
  // ---------------------------------------------------------------
  logic [4:0] irq_status_ff, irq_mask_ff, irq_evt;
  logic [31:0] prdata_ff;
  logic wr_acc, rd_acc, mapped;

  assign irq_evt = {arb_lost, ara_done, sense.over_170, |short_evt, |open_evt};
  assign mapped = paddr == OFS_OPEN_STATUS || paddr == OFS_SHORT_STATUS ||
                  paddr == OFS_IRQ_STATUS || paddr == OFS_IRQ_MASK ||
                  paddr == OFS_CTRL || paddr == OFS_STATE;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;
  assign irq = |(irq_status_ff & irq_mask_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= 5'h00;
      irq_mask_ff <= IRQ_MASK_RST;
      ctrl_enable_ff <= CTRL_RST;
    end else begin
      if (wr_acc && paddr == OFS_IRQ_STATUS) begin
        irq_status_ff <= (irq_status_ff & ~pwdata[4:0]) | irq_evt;
      end else begin
        irq_status_ff <= irq_status_ff | irq_evt;
      end
      if (wr_acc && paddr == OFS_IRQ_MASK) begin
        irq_mask_ff <= pwdata[4:0];
      end
      if (wr_acc && paddr == OFS_CTRL) begin
        ctrl_enable_ff <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        OFS_OPEN_STATUS: prdata_ff <= {24'h000000, open_fault_status_ff};
        OFS_SHORT_STATUS: prdata_ff <= {24'h000000, short_fault_status_ff};
        OFS_IRQ_STATUS: prdata_ff <= {27'h0000000, irq_status_ff};
        OFS_IRQ_MASK: prdata_ff <= {27'h0000000, irq_mask_ff};
        OFS_CTRL: prdata_ff <= {31'h00000000, ctrl_enable_ff};
        OFS_STATE: prdata_ff <= {18'h00000, force_ff, 1'b0, ara_state_ff, heat_latched_ff,
                                 alert_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hard_open;
    (ctrl_enable_ff && |sense.above_hard) |=>
      (open_fault_status_ff & force_ff & $past(sense.above_hard)) == $past(sense.above_hard);
  endproperty
  a_hard_open: assert property (p_hard_open) else $error("open fault not latched");
  property p_short_qual;
    (sense.below_short[0] && short_cnt_ff[0] != QUAL_LAST) |=> short_cnt_ff[0] != 12'h000;
  endproperty
  a_short_qual: assert property (p_short_qual) else $error("short counter stuck");
  property p_short_no_force;
    !sense.over_170 |=> (force_ff & ~$past(force_ff) & ~$past(open_evt)) == 8'h00;
  endproperty
  a_short_no_force: assert property (p_short_no_force) else $error("short forced switch");
  property p_heat_all;
    sense.over_170 |=> open_fault_status_ff == 8'hff && short_fault_status_ff == 8'hff &&
                       force_ff == 8'hff && alert_ff;
  endproperty
  a_heat_all: assert property (p_heat_all) else $error("overheat not applied");
  property p_heat_hold;
    (heat_latched_ff && !sense.below_160) |=> heat_latched_ff;
  endproperty
  a_heat_hold: assert property (p_heat_hold) else $error("overheat cleared while hot");
  property p_ara_keeps_status;
    (ara_done && !any_set_evt && hit_ch == 8'h00) |=>
      !alert_ff && $stable(open_fault_status_ff) && $stable(short_fault_status_ff);
  endproperty
  a_ara_keeps_status: assert property (p_ara_keeps_status) else $error("reply changed status");
  property p_no_ack_idle;
    (ara_state_ff == ARA_ADDR_RX && !alert_ff) |=> ara_state_ff != ARA_ACK;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle) else $error("acked while idle");
  property p_arb_release;
    arb_lost |=> !sda_oe_ff && ara_state_ff == ARA_WAIT;
  endproperty
  a_arb_release: assert property (p_arb_release) else $error("kept driving after loss");
  property p_clear_needs_write;
    (hit_ch == 8'h00) |=> (($past(open_fault_status_ff) & ~open_fault_status_ff) |
                           ($past(short_fault_status_ff) & ~short_fault_status_ff)) == 8'h00;
  endproperty
  a_clear_needs_write: assert property (p_clear_needs_write) else $error("bit lost");

endmodule

`default_nettype wire

// [bench/lfa_ara_master.sv]
// Serial bus master model that runs alert response queries.
`timescale 1ns/1ps
`default_nettype none
module lfa_ara_master (
  // Clock
  input wire logic pclk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int HALF = 20;
  localparam logic [7:0] QUERY = 8'h19;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge pclk);
  endtask
  task automatic clk_bit(input logic pull, output logic seen);
    sda_pull <= pull;
    tick();
    scl <= 1'b1;
    tick();
    seen = sda;
    scl <= 1'b0;
  endtask
  // One query; contend pulls the second reply bit low like a lower address would.
  task automatic query(input logic contend, output logic acked, output logic [7:0] reply);
    logic b;
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!QUERY[i], b);
    end
    clk_bit(1'b0, b);
    acked = !b;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(contend && i == 6, reply[i]);
    end
    clk_bit(1'b0, b);
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b0;
    tick();
  endtask
endmodule
`default_nettype wire

// [bench/led_fault_alert_reporting_bench.sv]
// Self-checking bench for the LED fault alert block.
`timescale 1ns/1ps
`default_nettype none
module led_fault_alert_reporting_bench;
  import lfa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, force_on;
  logic [31:0] pwdata, prdata;
  logic scl, sda, sda_out, sda_oe, m_pull, alert_n_out, alert_n_oe;
  logic [3:0] pins;
  lfa_sense_type sense;
  lfa_cmd_type cmd;
  int mismatches, checked;
  assign sda = !(sda_oe | m_pull);
  always #2.5 pclk = ~pclk;
  lfa_fault_alert uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pins(pins), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .sense(sense), .cmd(cmd), .force_switch_on(force_on), .irq(irq));
  lfa_ara_master m (.pclk(pclk), .sda(sda), .scl(scl), .sda_pull(m_pull));
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic send_cmd(input logic all, input logic [2:0] c, input logic ones);
    cmd.all_channel_command <= all;
    cmd.single_channel_command <= !all;
    cmd.channel <= c;
    cmd.data_all_ones <= ones;
    cmd.stop <= 1'b1;
    @(posedge pclk);
    cmd <= '0;
    wait_cyc(3);
  endtask
  function automatic logic [7:0] exp_reply(input logic [3:0] p);
    return {3'h2, p, 1'b1};
  endfunction
  // ---------------------------------------------------------------
  // Scenarios; alert_n_oe high means the alert is asserted
  // ---------------------------------------------------------------
  initial begin
    logic ak, e;
    logic [7:0] rep;
    logic [31:0] r;
    int ch, oc, ot;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sense = '0;
    sense.below_160 = 1'b1;
    cmd = '0;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'h51b60338));
    pins = 4'($urandom);
    ch = $urandom_range(7, 0);
    oc = ch ^ 1;
    ot = ch ^ 2;
    wait_cyc(12);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(alert_n_oe, 0);
    chk(force_on, 0);
    chk({pready, alert_n_out, sda_out}, 32'h4);
    rd(OFS_CTRL, 32'h1);
    rd(OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1);
    wr(OFS_CTRL, 32'h0);
    sense.above_hard[ot] <= 1'b1;
    wait_cyc(2);
    sense.above_hard[ot] <= 1'b0;
    rd(OFS_OPEN_STATUS, 32'h0);
    chk(alert_n_oe, 0);
    wr(OFS_CTRL, 32'h1);
    m.query(1'b0, ak, rep);
    chk(ak, 0);
    sense.above_hard[ch] <= 1'b1;
    @(posedge pclk);
    sense.above_hard[ch] <= 1'b0;
    wait_cyc(3);
    rd(OFS_OPEN_STATUS, 32'h1 << ch);
    chk({alert_n_oe, force_on, irq}, {1'b1, 8'h1 << ch, 1'b0});
    wr(OFS_IRQ_MASK, 32'h1f);
    chk(irq, 1);
    wr(OFS_IRQ_STATUS, 32'h1f);
    wait_cyc(2);
    chk(irq, 0);
    m.query(1'b0, ak, rep);
    chk({ak, rep}, {1'b1, exp_reply(pins)});
    chk(alert_n_oe, 0);
    rd(OFS_OPEN_STATUS, 32'h1 << ch);
    m.query(1'b0, ak, rep);
    chk(ak, 0);
    wr(OFS_IRQ_STATUS, 32'h1f);
    sense.below_short[oc] <= 1'b1;
    wait_cyc(2000);
    sense.below_short[oc] <= 1'b0;
    @(posedge pclk);
    sense.below_short[oc] <= 1'b1;
    wait_cyc(2990);
    rd(OFS_SHORT_STATUS, 32'h0);
    wait_cyc(20);
    rd(OFS_SHORT_STATUS, 32'h1 << oc);
    chk({alert_n_oe, force_on}, {1'b1, 8'h1 << ch});
    m.query(1'b1, ak, rep);
    chk(alert_n_oe, 1);
    rd(OFS_IRQ_STATUS, 32'h12);
    m.query(1'b0, ak, rep);
    chk({ak, alert_n_oe}, 2'h2);
    send_cmd(1'b0, 3'(ot), 1'b0);
    rd(OFS_OPEN_STATUS, 32'h1 << ch);
    send_cmd(1'b0, 3'(ch), 1'b0);
    rd(OFS_OPEN_STATUS, 32'h0);
    chk({force_on, alert_n_oe}, 9'h1);
    send_cmd(1'b0, 3'(oc), 1'b0);
    rd(OFS_SHORT_STATUS, 32'h1 << oc);
    sense.below_short[oc] <= 1'b0;
    send_cmd(1'b0, 3'(oc), 1'b0);
    rd(OFS_SHORT_STATUS, 32'h0);
    chk(alert_n_oe, 0);
    sense.above_open[ot] <= 1'b1;
    wait_cyc(2990);
    rd(OFS_OPEN_STATUS, 32'h0);
    wait_cyc(20);
    rd(OFS_OPEN_STATUS, 32'h1 << ot);
    sense.above_open[ot] <= 1'b0;
    send_cmd(1'b1, 3'h0, 1'b0);
    chk({force_on, alert_n_oe}, 9'h0);
    sense.below_160 <= 1'b0;
    sense.over_170 <= 1'b1;
    @(posedge pclk);
    sense.over_170 <= 1'b0;
    wait_cyc(3);
    rd(OFS_SHORT_STATUS, 32'hff);
    chk({force_on, alert_n_oe}, 9'h1ff);
    rd(OFS_STATE, 32'h3fc3);
    send_cmd(1'b1, 3'h0, 1'b0);
    rd(OFS_OPEN_STATUS, 32'hff);
    send_cmd(1'b1, 3'h0, 1'b1);
    rd(OFS_OPEN_STATUS, 32'hff);
    sense.below_160 <= 1'b1;
    send_cmd(1'b1, 3'h0, 1'b1);
    rd(OFS_OPEN_STATUS, 32'h0);
    chk(alert_n_oe, 0);
    tally_and_finish();
  end
  initial begin
    wait_cyc(60000);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
